//--- hdl/phy_mii_serial_data_port.sv
// data side of the mii / 10 Mbit/s serial port of a 10/100 transceiver
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - half duplex: collision is tx enable AND receive activity, combinational
// - serial 10 Mbit/s: collision output reports jabber timer expiry
// - full duplex: collision output held low
// - carrier sense on transmit or receive activity, through whole collision
// - receive-only select: carrier sense follows receive activity only
// - receive clock 20 MHz at 100 Mbit/s, 2.5 MHz nibble, 10 MHz serial
// - receive nibble changes on the falling edge of receive clock
// - 100 Mbit/s: error code 4h premature end, 5h coding error
// - packet 2h and link 3h codes only when their repeat enables set
// - serial 10 Mbit/s: data on bit 0, bits 3..1 floated
// - receive valid marks decoded nibbles, unused in serial mode
// - receive error flags coding errors, only in 100 Mbit/s
// - codec bypass: receive error pin carries fifth data bit, held low in serial mode
// - transmit clock 20 MHz at 100 Mbit/s, 2.5 MHz nibble, 10 MHz serial
// - transmit inputs sampled on rising edge of transmit clock
// - only nibbles with transmit enable high are frame data
// - serial 10 Mbit/s: only transmit bit 0 used
// - transmit error corrupts the group, sending 00100
// - bypass: transmit error is fifth bit; ignored in serial mode
// - receive outputs enabled only while receive enable is high
module phy_mii_serial_data_port
    import phy_mii_pkg::*;
(
    // system
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // line side, from the receive decoder and jabber logic
    input wire logic line_rx_active,
    input wire logic line_rx_dv,
    input wire logic [4:0] line_rx_data,
    input wire logic [2:0] line_rx_err,
    input wire logic jabber_expired,
    // line side, to the transmit encoder
    output logic tx_sym_valid,
    output logic [4:0] tx_sym_data,
    output logic tx_sym_corrupt,
    // mii transmit pins
    input wire logic tx_en,
    input wire logic [3:0] txd,
    input wire logic tx_er,
    output logic tx_clk,
    // mii receive pins
    input wire logic rx_en,
    output logic rx_clk_o,
    output logic rx_clk_oe,
    output logic [3:0] rxd_o,
    output logic [3:0] rxd_oe,
    output logic rx_dv_o,
    output logic rx_dv_oe,
    output logic rx_er_o,
    output logic rx_er_oe,
    // status pins
    output logic col,
    output logic crs
);

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic tx_en_s;
    logic [3:0] txd_s;
    logic tx_er_s;
    logic rx_en_s;

    sync2 #(
        .W(7)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d({tx_en, txd, tx_er, rx_en}),
        .q({tx_en_s, txd_s, tx_er_s, rx_en_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // control and status registers

    logic [15:0] ctrl_reg;
    logic [15:0] rdata_reg;
    logic [15:0] status_word;
    logic ctl_speed_100;
    logic ctl_serial;
    logic ctl_full_duplex;
    logic carrier_rx_only_select;
    logic ctl_bypass;
    logic ctl_rep_packet;
    logic ctl_rep_link;
    logic serial10;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (reg_wr && reg_addr == CTRL_OFFSET) begin
            ctrl_reg <= reg_wdata & CTRL_MASK;
        end
    end

    always_comb begin
        status_word = 16'h0000;
        status_word[ST_RX_EN_BIT] = rx_en_s;
        status_word[ST_TX_EN_BIT] = tx_en_s;
        status_word[ST_RX_ACTIVE_BIT] = line_rx_active;
        status_word[ST_COL_BIT] = col;
        status_word[ST_CRS_BIT] = crs;
        status_word[ST_JABBER_BIT] = jabber_expired;
    end

    // read data stand for one cycle only; unmapped offsets read zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= 16'h0000;
        end else if (reg_rd && reg_addr == CTRL_OFFSET) begin
            rdata_reg <= ctrl_reg;
        end else if (reg_rd && reg_addr == STATUS_OFFSET) begin
            rdata_reg <= status_word;
        end else begin
            rdata_reg <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_reg;

    assign ctl_speed_100 = ctrl_reg[CTRL_SPEED_100_BIT];
    assign ctl_serial = ctrl_reg[CTRL_SERIAL_BIT];
    assign ctl_full_duplex = ctrl_reg[CTRL_FULL_DUPLEX_BIT];
    assign carrier_rx_only_select = ctrl_reg[CTRL_CARRIER_RX_ONLY_BIT];
    assign ctl_bypass = ctrl_reg[CTRL_BYPASS_BIT];
    assign ctl_rep_packet = ctrl_reg[CTRL_REP_PACKET_BIT];
    assign ctl_rep_link = ctrl_reg[CTRL_REP_LINK_BIT];
    assign serial10 = ctl_serial && !ctl_speed_100;

    ////////////////////////////////////////////////////////////////////////////
    // mii clocks

    mii_clk_if tx_ck ();
    mii_clk_if rx_ck ();
    logic [7:0] half_sel;

    always_comb begin
        if (ctl_speed_100) begin
            half_sel = HALF_100;
        end else if (ctl_serial) begin
            half_sel = HALF_SER;
        end else begin
            half_sel = HALF_NIB;
        end
    end

    assign tx_ck.half_cnt = half_sel;
    assign rx_ck.half_cnt = half_sel;

    mii_clk_gen u_tx_clk (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ck(tx_ck)
    );

    mii_clk_gen u_rx_clk (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .ck(rx_ck)
    );

    assign tx_clk = tx_ck.level;

    ////////////////////////////////////////////////////////////////////////////
    // collision and carrier sense

    always_comb begin
        if (ctl_full_duplex) begin
            col = 1'b0;
        end else if (serial10) begin
            col = jabber_expired;
        end else begin
            col = tx_en_s && line_rx_active;
        end
    end

    always_comb begin
        if (carrier_rx_only_select) begin
            crs = line_rx_active;
        end else begin
            crs = line_rx_active || tx_en_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // transmit sampling

    logic [4:0] tx_group_next;
    logic tx_corrupt_next;

    always_comb begin
        tx_corrupt_next = 1'b0;
        if (serial10) begin
            tx_group_next = {4'h0, txd_s[0]};
        end else if (ctl_bypass) begin
            tx_group_next = {tx_er_s, txd_s};
        end else if (tx_er_s) begin
            tx_group_next = TX_CORRUPT_GROUP;
            tx_corrupt_next = 1'b1;
        end else begin
            tx_group_next = {1'b0, txd_s};
        end
    end

    // inputs are taken only at the tick where tx_clk rises
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tx_sym_valid <= 1'b0;
            tx_sym_data <= 5'h00;
            tx_sym_corrupt <= 1'b0;
        end else if (tx_ck.rise && tx_en_s) begin
            tx_sym_valid <= 1'b1;
            tx_sym_data <= tx_group_next;
            tx_sym_corrupt <= tx_corrupt_next;
        end else begin
            tx_sym_valid <= 1'b0;
            tx_sym_corrupt <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receive output

    rx_err_kind_t err_kind;
    logic [3:0] rxd_next;
    logic rx_dv_next;
    logic rx_er_next;
    logic [3:0] rxd_reg;
    logic rx_dv_reg;
    logic rx_er_reg;

    assign err_kind = rx_err_kind_t'(line_rx_err);

    always_comb begin
        rxd_next = line_rx_data[3:0];
        rx_dv_next = line_rx_dv;
        rx_er_next = 1'b0;
        if (serial10) begin
            rxd_next = {3'b000, line_rx_data[0]};
            rx_dv_next = 1'b0;
        end else if (ctl_bypass) begin
            rx_er_next = line_rx_data[4];
        end else if (ctl_speed_100 && line_rx_dv) begin
            unique case (err_kind)
                ERR_NONE: begin
                    rx_er_next = 1'b0;
                end
                ERR_PACKET: begin
                    if (ctl_rep_packet) begin
                        rx_er_next = 1'b1;
                        rxd_next = ERR_CODE_PACKET;
                    end
                end
                ERR_LINK: begin
                    if (ctl_rep_link) begin
                        rx_er_next = 1'b1;
                        rxd_next = ERR_CODE_LINK;
                    end
                end
                ERR_PREMATURE: begin
                    rx_er_next = 1'b1;
                    rxd_next = ERR_CODE_PREMATURE;
                end
                ERR_CODING: begin
                    rx_er_next = 1'b1;
                    rxd_next = ERR_CODE_CODING;
                end
                default: begin
                    rx_er_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxd_reg <= 4'h0;
            rx_dv_reg <= 1'b0;
            rx_er_reg <= 1'b0;
        end else if (rx_ck.fall) begin
            rxd_reg <= rxd_next;
            rx_dv_reg <= rx_dv_next;
            rx_er_reg <= rx_er_next;
        end
    end

    assign rx_clk_o = rx_ck.level;
    assign rxd_o = rxd_reg;
    assign rx_dv_o = rx_dv_reg;
    assign rx_er_o = rx_er_reg;

    // enables float the receive bus so several ports can share it
    assign rx_clk_oe = rx_en_s;
    assign rx_dv_oe = rx_en_s;
    assign rx_er_oe = rx_en_s;
    assign rxd_oe = rx_en_s ? (serial10 ? 4'h1 : 4'hf) : 4'h0;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_col_and_logic: assert property (
        !ctl_full_duplex && !serial10 |-> col == (tx_en_s && line_rx_active))
        else $error("collision is not tx enable and rx activity");

    a_col_jabber: assert property (
        !ctl_full_duplex && serial10 |-> col == jabber_expired)
        else $error("collision does not show jabber in serial mode");

    a_col_fdx_low: assert property (
        ctl_full_duplex |-> !col)
        else $error("collision high in full duplex");

    a_crs_both_paths: assert property (
        !carrier_rx_only_select && (tx_en_s || line_rx_active) |-> crs)
        else $error("carrier sense missing for activity");

    a_crs_rx_only: assert property (
        carrier_rx_only_select |-> crs == line_rx_active)
        else $error("carrier sense not receive only");

    a_rxd_fall_only: assert property (
        !$past(rx_ck.fall) |-> $stable(rxd_o))
        else $error("receive data changed away from falling edge");

    a_rx_code_error: assert property (
        rx_ck.fall && ctl_speed_100 && !ctl_bypass && line_rx_dv && err_kind == ERR_CODING
        |=> rx_er_o && rxd_o == 4'h5)
        else $error("coding error not reported with 5h");

    a_rx_link_gated: assert property (
        rx_ck.fall && ctl_speed_100 && !ctl_bypass && line_rx_dv && err_kind == ERR_LINK && !ctl_rep_link
        |=> !rx_er_o)
        else $error("link error repeated while disabled");

    a_rxd_serial_float: assert property (
        serial10 |-> rxd_oe[3:1] == 3'b000)
        else $error("upper receive bits driven in serial mode");

    a_rx_dv_serial: assert property (
        rx_ck.fall && serial10 |=> !rx_dv_o)
        else $error("receive valid raised in serial mode");

    a_tx_corrupt_group: assert property (
        tx_ck.rise && tx_en_s && tx_er_s && !ctl_bypass && !serial10
        |=> tx_sym_valid && tx_sym_corrupt && tx_sym_data == 5'h04)
        else $error("transmit error did not send 00100");

    a_tx_only_enabled: assert property (
        tx_sym_valid |-> $past(tx_en_s) && $past(tx_ck.rise))
        else $error("symbol passed without transmit enable");

    a_rx_float_off: assert property (
        !rx_en_s |-> !rx_clk_oe && !rx_dv_oe && !rx_er_oe && rxd_oe == 4'h0)
        else $error("receive output driven while disabled");

endmodule : phy_mii_serial_data_port

//--- hdl/phy_mii_pkg.sv
// constants and types shared by the mii/serial data port
package phy_mii_pkg;

    // clock rates in kHz
    localparam int SYS_CLK_KHZ = 40000;
    localparam int MII_100_KHZ = 25000;
    localparam int MII_10_NIB_KHZ = 2500;
    localparam int MII_10_SER_KHZ = 10000;

    // half periods of the generated mii clocks in clk_sys cycles, at least one
    localparam int HALF_100_RAW = SYS_CLK_KHZ / (2 * MII_100_KHZ);
    localparam int HALF_NIB_RAW = SYS_CLK_KHZ / (2 * MII_10_NIB_KHZ);
    localparam int HALF_SER_RAW = SYS_CLK_KHZ / (2 * MII_10_SER_KHZ);
    localparam logic [7:0] HALF_100 = 8'((HALF_100_RAW < 1) ? 1 : HALF_100_RAW);
    localparam logic [7:0] HALF_NIB = 8'((HALF_NIB_RAW < 1) ? 1 : HALF_NIB_RAW);
    localparam logic [7:0] HALF_SER = 8'((HALF_SER_RAW < 1) ? 1 : HALF_SER_RAW);

    // register offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // control register fields
    localparam int CTRL_SPEED_100_BIT = 0;
    localparam int CTRL_SERIAL_BIT = 1;
    localparam int CTRL_FULL_DUPLEX_BIT = 2;
    localparam int CTRL_CARRIER_RX_ONLY_BIT = 3;
    localparam int CTRL_BYPASS_BIT = 4;
    localparam int CTRL_REP_PACKET_BIT = 5;
    localparam int CTRL_REP_LINK_BIT = 6;
    localparam logic [15:0] CTRL_MASK = 16'h007f;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // status register fields
    localparam int ST_RX_EN_BIT = 0;
    localparam int ST_TX_EN_BIT = 1;
    localparam int ST_RX_ACTIVE_BIT = 2;
    localparam int ST_COL_BIT = 3;
    localparam int ST_CRS_BIT = 4;
    localparam int ST_JABBER_BIT = 5;

    // receive error codes and transmit corruption group
    localparam logic [3:0] ERR_CODE_PACKET = 4'h2;
    localparam logic [3:0] ERR_CODE_LINK = 4'h3;
    localparam logic [3:0] ERR_CODE_PREMATURE = 4'h4;
    localparam logic [3:0] ERR_CODE_CODING = 4'h5;
    localparam logic [4:0] TX_CORRUPT_GROUP = 5'h04;

    typedef enum logic [2:0] {
        ERR_NONE = 3'b000,
        ERR_PACKET = 3'b001,
        ERR_LINK = 3'b010,
        ERR_PREMATURE = 3'b011,
        ERR_CODING = 3'b100
    } rx_err_kind_t;

endpackage : phy_mii_pkg

//--- hdl/mii_clk_if.sv
// generated mii clock: half period in, level and edge ticks out
`timescale 1ns/1ps
interface mii_clk_if;
    logic [7:0] half_cnt;
    logic level;
    logic rise;
    logic fall;

    modport gen (input half_cnt, output level, output rise, output fall);
    modport user (output half_cnt, input level, input rise, input fall);
endinterface : mii_clk_if

//--- hdl/mii_clk_gen.sv
// divider that makes one mii clock from clk_sys
`timescale 1ns/1ps
module mii_clk_gen (
    // system
    input wire logic clk_sys,
    input wire logic rst_n,
    // generated clock
    mii_clk_if.gen ck
);
    logic [7:0] cnt_reg;
    logic level_reg;
    logic wrap;

    // >= so a smaller half period after a mode change wraps at once
    assign wrap = (cnt_reg >= (ck.half_cnt - 8'd1));

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00;
            level_reg <= 1'b0;
        end else if (wrap) begin
            cnt_reg <= 8'h00;
            level_reg <= ~level_reg;
        end else begin
            cnt_reg <= cnt_reg + 8'd1;
        end
    end

    assign ck.level = level_reg;
    assign ck.rise = wrap && !level_reg;
    assign ck.fall = wrap && level_reg;

    // the first half period after a mode change may end early, so it is skipped
    a_clk_half_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(level_reg) && $stable(ck.half_cnt) && $past(ck.half_cnt, 2) == ck.half_cnt
        |-> $past(cnt_reg) == ck.half_cnt - 8'd1)
        else $error("mii clock half period wrong");

endmodule : mii_clk_gen

//--- hdl/sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    // system
    input wire logic clk_sys,
    input wire logic rst_n,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;

endmodule : sync2

//--- dv/mac_model.sv
// behavioural mac driving the mii transmit pins of the port
`timescale 1ns/1ps
module mac_model (
    // system
    input wire logic clk_sys,
    // mii transmit
    input wire logic tx_clk,
    input wire logic hold_en,
    output logic tx_en,
    output logic [3:0] txd,
    output logic tx_er
);
    logic [4:0] sent_q[$];
    logic [4:0] v;
    logic clk_d;
    int left;

    initial begin
        tx_en = 1'b0;
        txd = 4'h0;
        tx_er = 1'b0;
        clk_d = 1'b0;
        left = 0;
    end

    // pins change just after tx_clk rises, one nibble a period
    always @(posedge clk_sys) begin
        clk_d <= tx_clk;
        if (tx_clk === 1'b1 && clk_d === 1'b0) begin
            if (left > 0) begin
                v = 5'($urandom);
                tx_en <= 1'b1;
                txd <= v[3:0];
                tx_er <= v[4];
                sent_q.push_back(v);
                left <= left - 1;
            end else begin
                // outside a frame the data lines keep toggling, never a stale nibble
                tx_en <= hold_en;
                txd <= ~txd;
                tx_er <= ~tx_er;
            end
        end
    end
endmodule : mac_model

//--- dv/phy_mii_serial_data_port_tb_top.sv
// self-checking bench for the mii / serial data port
`timescale 1ns/1ps
module phy_mii_serial_data_port_tb_top import phy_mii_pkg::*;;
    logic clk_sys, rst_n, reg_wr, reg_rd, line_rx_active, line_rx_dv, jabber_expired, hold_en;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [4:0] line_rx_data, tx_sym_data;
    logic [2:0] line_rx_err;
    logic tx_sym_valid, tx_sym_corrupt, tx_en, tx_er, tx_clk, rx_en, rx_clk_o, rx_clk_oe;
    logic [3:0] txd, rxd_o, rxd_oe;
    logic rx_dv_o, rx_dv_oe, rx_er_o, rx_er_oe, col, crs;
    logic [5:0] got_q[$];
    int fails = 0;
    int comparisons = 0;

    phy_mii_serial_data_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .line_rx_active(line_rx_active), .line_rx_dv(line_rx_dv), .line_rx_data(line_rx_data),
        .line_rx_err(line_rx_err), .jabber_expired(jabber_expired), .tx_sym_valid(tx_sym_valid),
        .tx_sym_data(tx_sym_data), .tx_sym_corrupt(tx_sym_corrupt), .tx_en(tx_en), .txd(txd),
        .tx_er(tx_er), .tx_clk(tx_clk), .rx_en(rx_en), .rx_clk_o(rx_clk_o), .rx_clk_oe(rx_clk_oe),
        .rxd_o(rxd_o), .rxd_oe(rxd_oe), .rx_dv_o(rx_dv_o), .rx_dv_oe(rx_dv_oe), .rx_er_o(rx_er_o),
        .rx_er_oe(rx_er_oe), .col(col), .crs(crs));
    mac_model mac (.clk_sys(clk_sys), .tx_clk(tx_clk), .hold_en(hold_en), .tx_en(tx_en),
        .txd(txd), .tx_er(tx_er));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (tx_sym_valid === 1'b1) got_q.push_back({tx_sym_corrupt, tx_sym_data});
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // cycles up to the next tx_clk rise or rx_clk_o fall, bounded
    task automatic wait_edge(input bit tx, output int n);
        logic p, s;
        // settle first so an edge launched at the calling edge is not counted later
        #1;
        p = tx ? tx_clk : !rx_clk_o;
        for (n = 1; n < 60; n++) begin
            @(posedge clk_sys);
            #1;
            s = tx ? tx_clk : !rx_clk_o;
            if (s === 1'b1 && p === 1'b0) return;
            p = s;
        end
        fails++;
        end_of_test();
    endtask : wait_edge

    ////////////////////////////////////////////////////////////////////////////////
    function automatic int per(logic [7:0] c);
        if (c[1] && !c[0]) return 2 * HALF_SER;
        return c[0] ? 2 * HALF_100 : 2 * HALF_NIB;
    endfunction : per

    function automatic logic [5:0] tx_exp(logic [7:0] c, logic [4:0] v);
        if (c[1] && !c[0]) return {5'h00, v[0]};
        if (c[4]) return {1'b0, v};
        if (v[4]) return {1'b1, TX_CORRUPT_GROUP};
        return {2'b00, v[3:0]};
    endfunction : tx_exp

    // m is {line valid, error kind}; returns {rxd, rx_dv, rx_er}
    function automatic logic [5:0] rx_exp(logic [7:0] c, logic [3:0] m, logic [4:0] d);
        if (c[1] && !c[0]) return {3'b000, d[0], 2'b00};
        if (c[4]) return {d[3:0], m[3], d[4]};
        if (c[0] && m == 4'hc) return {ERR_CODE_CODING, 2'b11};
        if (c[0] && m == 4'hb) return {ERR_CODE_PREMATURE, 2'b11};
        if (c[0] && m == 4'h9 && c[5]) return {ERR_CODE_PACKET, 2'b11};
        if (c[0] && m == 4'ha && c[6]) return {ERR_CODE_LINK, 2'b11};
        return {d[3:0], m[3], 1'b0};
    endfunction : rx_exp

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [15:0] d;
        logic [7:0] c;
        logic [12:0] ct[8];
        logic [11:0] rt[10];
        logic [7:0] tm[4];
        int n, i, k;
        ct = '{{8'h00, 5'b11011}, {8'h00, 5'b10001}, {8'h00, 5'b00100}, {8'h04, 5'b11001},
            {8'h08, 5'b10000}, {8'h08, 5'b01001}, {8'h02, 5'b00110}, {8'h02, 5'b01111}};
        rt = '{{8'h01, 4'hc}, {8'h01, 4'hb}, {8'h01, 4'h9}, {8'h21, 4'h9}, {8'h41, 4'ha},
            {8'h00, 4'hc}, {8'h02, 4'h8}, {8'h11, 4'h8}, {8'h01, 4'h0}, {8'h01, 4'ha}};
        tm = '{8'h00, 8'h10, 8'h02, 8'h01};
        void'($urandom(9461));
        rst_n = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        {reg_wr, reg_rd, line_rx_active, line_rx_dv, jabber_expired, hold_en} = 6'h00;
        line_rx_data = 5'h00;
        line_rx_err = 3'h0;
        rx_en = 1'b1;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(CTRL_OFFSET, d);
        chk("ctrl reset", d, CTRL_RESET);
        wr(CTRL_OFFSET, 16'hffff);
        rd(CTRL_OFFSET, d);
        chk("ctrl mask", d, CTRL_MASK);
        rd(8'h08, d);
        chk("unmapped read", d, 16'h0000);
        // collision and carrier sense across modes
        for (i = 0; i < 8; i++) begin
            wr(CTRL_OFFSET, {8'h00, ct[i][12:5]});
            hold_en <= ct[i][4];
            line_rx_active <= ct[i][3];
            jabber_expired <= ct[i][2];
            wait_edge(1, n);
            wait_edge(1, n);
            chk("col", col, ct[i][1]);
            chk("crs", crs, ct[i][0]);
            rd(STATUS_OFFSET, d);
            chk("status", d, {10'h000, ct[i][2], ct[i][0], ct[i][1], ct[i][3], ct[i][4], 1'b1});
        end
        hold_en <= 1'b0;
        line_rx_active <= 1'b0;
        jabber_expired <= 1'b0;
        // transmit path in nibble, bypass, serial and 100 Mbit/s modes
        for (i = 0; i < 4; i++) begin
            c = tm[i];
            wr(CTRL_OFFSET, {8'h00, c});
            wait_edge(1, n);
            wait_edge(1, n);
            chk("tx_clk period", 16'(n), 16'(per(c)));
            got_q.delete();
            mac.sent_q.delete();
            mac.left = 8;
            for (k = 0; k < 400 && mac.left > 0; k++) @(posedge clk_sys);
            chk("tx frame sent", 16'(mac.left), 16'h0000);
            if (mac.left != 0) end_of_test();
            wait_edge(1, n);
            wait_edge(1, n);
            chk("tx group count", 16'(got_q.size()), 16'd8);
            for (k = 0; k < 8; k++) chk("tx group", got_q[k], tx_exp(c, mac.sent_q[k]));
        end
        // receive path, every error kind and mode
        for (i = 0; i < 10; i++) begin
            c = rt[i][11:4];
            wr(CTRL_OFFSET, {8'h00, c});
            line_rx_dv <= rt[i][3];
            line_rx_err <= rt[i][2:0];
            line_rx_data <= 5'($urandom);
            wait_edge(0, n);
            wait_edge(0, n);
            chk("rx_clk period", 16'(n), 16'(per(c)));
            chk("rx pins", {rxd_o, rx_dv_o, rx_er_o}, rx_exp(c, rt[i][3:0], line_rx_data));
            chk("rxd oe", rxd_oe, (c[1] && !c[0]) ? 4'h1 : 4'hf);
        end
        // receive outputs float while rx_en is low
        wr(CTRL_OFFSET, 16'h0000);
        rx_en <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("rx oe off", {rx_clk_oe, rxd_oe, rx_dv_oe, rx_er_oe}, 16'h0000);
        rx_en <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("rx oe on", {rx_clk_oe, rxd_oe, rx_dv_oe, rx_er_oe}, 16'h007f);
        end_of_test();
    end
endmodule : phy_mii_serial_data_port_tb_top
